// *** rtl/sdb_data_buffers.sv ***
// Receive, emulation and transmit data buffers with an APB slave and a transmit queue.
`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO with valid/ready on both sides.
module sdb_fifo #(
    parameter int Width = 11,
    parameter int Depth = 32
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Filling side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [Width-1:0] inData,
    // Draining side.
    output logic outValid,
    input wire logic outReady,
    output logic [Width-1:0] outData
);
    // Index width; the extra wrap bit tells a full queue from an empty one.
    localparam int PtrW = $clog2(Depth);

    logic [Width-1:0] mem [Depth];  // Storage words.
    logic [PtrW:0] wrPtr_q;  // Write pointer with wrap bit.
    logic [PtrW:0] rdPtr_q;  // Read pointer with wrap bit.
    logic pushEn;
    logic popEn;

    // Full when the indices match and the wrap bits differ.
    assign inReady = !((wrPtr_q[PtrW] != rdPtr_q[PtrW]) &&
                       (wrPtr_q[PtrW-1:0] == rdPtr_q[PtrW-1:0]));
    assign outValid = (wrPtr_q != rdPtr_q);
    assign pushEn = inValid && inReady;
    assign popEn = outValid && outReady;
    assign outData = mem[rdPtr_q[PtrW-1:0]];

    // Store the incoming word.
    always_ff @(posedge mclk) begin
        if (pushEn) begin
            mem[wrPtr_q[PtrW-1:0]] <= inData;
        end
    end

    // Advance the pointers.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (pushEn) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (popEn) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule // sdb_fifo

// Data-buffer stage of the serial interface.
module sdb_data_buffers #(
    parameter int FifoDepth = sdb_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sdb_pkg::ADDR_W-1:0] paddr,
    input wire logic [sdb_pkg::BUS_W-1:0] pwdata,
    output logic [sdb_pkg::BUS_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive shift register side.
    input wire logic rxDone,
    input wire sdb_pkg::sdb_rxchar_t rxChar,
    // Transmit shift register side.
    output logic txValid,
    input wire logic txReady,
    output sdb_pkg::sdb_txchar_t txChar,
    // Configuration and events.
    output logic sciMode,
    output logic [sdb_pkg::LEN_W-1:0] charLen,
    output logic rxInt,
    output logic txInt
);
    logic [sdb_pkg::DATA_W-1:0] rxData_q;  // Receive storage shared by two views.
    logic rxReady_q;  // Receive-ready flag.
    logic [sdb_pkg::DATA_W-1:0] txData_q;  // Transmit buffer.
    logic txFull_q;  // Transmit buffer holds a byte not yet moved.
    logic transmit_ready_flag_q;  // Transmit-ready flag.
    logic rxIrqEn_q;  // Receive interrupt enable.
    logic txIrqEn_q;  // Transmit interrupt enable.
    logic sci_q;  // SCI-compatible mode.
    logic [sdb_pkg::LEN_W-1:0] len_q;  // Character length minus one.
    logic rxInt_q;  // Receive interrupt pulse.
    logic txInt_q;  // Transmit interrupt pulse.
    logic [sdb_pkg::BUS_W-1:0] prdata_q;  // Read data captured in setup.
    logic setupRd;
    logic accWr;
    logic accRd;
    logic mapped;
    logic charLoad;
    logic txMove;
    logic fifoReady;
    logic [sdb_pkg::DATA_W-1:0] rxAligned;
    logic [sdb_pkg::BUS_W-1:0] readMux;
    sdb_pkg::sdb_txchar_t pushChar;

    // Low-order mask holding len+1 ones.
    function automatic logic [sdb_pkg::DATA_W-1:0] lenMask(
        input logic [sdb_pkg::LEN_W-1:0] len);
        lenMask = sdb_pkg::DATA_MASK >> (sdb_pkg::LEN_MAX - len);
    endfunction

    // Bus phase decode; the slave never inserts wait states.
    assign setupRd = psel && !penable && !pwrite;
    assign accWr = psel && penable && pwrite;
    assign accRd = psel && penable && !pwrite;
    assign mapped = (paddr == sdb_pkg::OFS_EMUL) || (paddr == sdb_pkg::OFS_RXBUF) ||
                    (paddr == sdb_pkg::OFS_TXBUF) || (paddr == sdb_pkg::OFS_INTSET) ||
                    (paddr == sdb_pkg::OFS_FLAG) || (paddr == sdb_pkg::OFS_CTRL);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    // Received bits moved to the top, low positions zero.
    assign rxAligned = (rxChar.bits & lenMask(rxChar.len)) << (sdb_pkg::LEN_MAX - rxChar.len);
    assign charLoad = rxDone && sci_q;

    // Transmit move waits out a write cycle so the flag never sees both events.
    assign txMove = txFull_q && sci_q && fifoReady &&
                    !(accWr && (paddr == sdb_pkg::OFS_TXBUF));
    assign pushChar.len = len_q;
    assign pushChar.data = txData_q & lenMask(len_q);

    assign sciMode = sci_q;
    assign charLen = len_q;
    assign rxInt = rxInt_q;
    assign txInt = txInt_q;

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        readMux = sdb_pkg::BUS_ZERO;
        case (paddr)
            sdb_pkg::OFS_EMUL, sdb_pkg::OFS_RXBUF: begin
                readMux[sdb_pkg::DATA_W-1:0] = rxData_q;
            end
            sdb_pkg::OFS_TXBUF: begin
                readMux[sdb_pkg::DATA_W-1:0] = txData_q;
            end
            sdb_pkg::OFS_INTSET: begin
                readMux[sdb_pkg::INT_RX_BIT] = rxIrqEn_q;
                readMux[sdb_pkg::INT_TX_BIT] = txIrqEn_q;
            end
            sdb_pkg::OFS_FLAG: begin
                readMux[sdb_pkg::FLAG_RX_READY_BIT] = rxReady_q;
                readMux[sdb_pkg::FLAG_TX_READY_BIT] = transmit_ready_flag_q;
            end
            sdb_pkg::OFS_CTRL: begin
                readMux[sdb_pkg::CTRL_SCI_BIT] = sci_q;
                readMux[sdb_pkg::CTRL_LEN_LSB +: sdb_pkg::LEN_W] = len_q;
            end
            default: begin
                readMux = sdb_pkg::BUS_ZERO;
            end
        endcase
    end

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= sdb_pkg::BUS_ZERO;
        end else if (setupRd) begin
            prdata_q <= readMux;
        end
    end

    // Configuration registers written in any mode.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sci_q <= 1'b0;
            len_q <= sdb_pkg::LEN_RESET;
            rxIrqEn_q <= 1'b0;
            txIrqEn_q <= 1'b0;
        end else if (accWr) begin
            if (paddr == sdb_pkg::OFS_CTRL) begin
                sci_q <= pwdata[sdb_pkg::CTRL_SCI_BIT];
                len_q <= pwdata[sdb_pkg::CTRL_LEN_LSB +: sdb_pkg::LEN_W];
            end
            if (paddr == sdb_pkg::OFS_INTSET) begin
                rxIrqEn_q <= pwdata[sdb_pkg::INT_RX_BIT];
                txIrqEn_q <= pwdata[sdb_pkg::INT_TX_BIT];
            end
        end
    end

    // Receive storage: a completed character wins over a bus write.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rxData_q <= sdb_pkg::DATA_RESET;
        end else if (charLoad) begin
            rxData_q <= rxAligned;
        end else if (accWr && sci_q && (paddr == sdb_pkg::OFS_RXBUF)) begin
            rxData_q <= pwdata[sdb_pkg::DATA_W-1:0];
        end
    end

    // Receive-ready flag: a load in the same cycle as a read keeps it set.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rxReady_q <= 1'b0;
        end else if (charLoad) begin
            rxReady_q <= 1'b1;
        end else if (accRd && (paddr == sdb_pkg::OFS_RXBUF)) begin
            rxReady_q <= 1'b0;
        end
    end

    // Interrupt pulses, one cycle after the event.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rxInt_q <= 1'b0;
            txInt_q <= 1'b0;
        end else begin
            rxInt_q <= charLoad && rxIrqEn_q;
            txInt_q <= txMove && txIrqEn_q;
        end
    end

    // Transmit buffer, writable only in SCI mode.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            txData_q <= sdb_pkg::DATA_RESET;
        end else if (accWr && sci_q && (paddr == sdb_pkg::OFS_TXBUF)) begin
            txData_q <= pwdata[sdb_pkg::DATA_W-1:0];
        end
    end

    // Buffer occupancy and transmit-ready flag move together.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            txFull_q <= 1'b0;
            transmit_ready_flag_q <= 1'b1;
        end else if (accWr && sci_q && (paddr == sdb_pkg::OFS_TXBUF)) begin
            txFull_q <= 1'b1;
            transmit_ready_flag_q <= 1'b0;
        end else if (txMove) begin
            txFull_q <= 1'b0;
            transmit_ready_flag_q <= 1'b1;
        end
    end

    // Queue between the transmit buffer and the transmit shift register.
    sdb_fifo #(
        .Width($bits(sdb_pkg::sdb_txchar_t)),
        .Depth(FifoDepth)
    ) txQueue (
        .mclk(mclk),
        .reset_n(reset_n),
        .inValid(txMove),
        .inReady(fifoReady),
        .inData(pushChar),
        .outValid(txValid),
        .outReady(txReady),
        .outData(txChar)
    );

    // All checks run on the module clock and sleep while reset is held.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // A completed character that the mode lets through.
    sequence rxLoadSeq;
        rxDone && sci_q;
    endsequence

    // A normal receive buffer read with no load in the same cycle.
    sequence rxReadSeq;
        accRd && (paddr == sdb_pkg::OFS_RXBUF) && !(rxDone && sci_q);
    endsequence

    // A software write that fills the transmit buffer.
    sequence txWriteSeq;
        accWr && sci_q && (paddr == sdb_pkg::OFS_TXBUF);
    endsequence

    // The buffer contents moving on towards the transmit shift register.
    sequence txMoveSeq;
        txFull_q && sci_q && fifoReady && !(accWr && (paddr == sdb_pkg::OFS_TXBUF));
    endsequence

    // Properties of the receive path, then of the transmit path.
    a_rx_copy: assert property (rxLoadSeq |=> rxData_q == $past(rxAligned))
        else $error("Receive buffer did not take the completed character.");
    a_rx_align: assert property (rxLoadSeq |=>
        8'(rxData_q << ({1'b0, $past(rxChar.len)} + 4'h1)) == 8'h00)
        else $error("Short received character not padded with low zeros.");
    a_rx_flag_irq: assert property (rxLoadSeq ##0 rxIrqEn_q |=> rxReady_q && rxInt)
        else $error("Receive load missed its flag or interrupt.");
    a_rd_clears: assert property (rxReadSeq |=> !rxReady_q && !rxInt)
        else $error("Normal receive read left the ready flag set.");
    a_emul_keeps: assert property (accRd && (paddr == sdb_pkg::OFS_EMUL) && rxReady_q
        |=> rxReady_q)
        else $error("Emulation read cleared the ready flag.");
    a_emul_same: assert property (setupRd && (paddr == sdb_pkg::OFS_EMUL)
        |=> prdata == {24'h00_0000, $past(rxData_q)})
        else $error("Emulation view differs from receive storage.");
    a_upper_zero: assert property (setupRd && (paddr <= sdb_pkg::OFS_TXBUF) |=>
        prdata[sdb_pkg::BUS_W-1:sdb_pkg::DATA_W] == 24'h00_0000)
        else $error("Buffer read showed bits above the data field.");
    a_tx_cycle: assert property (txWriteSeq ##1 txMoveSeq |=> transmit_ready_flag_q && !txFull_q)
        else $error("Transfer to shifter did not set transmit-ready.");
    a_tx_irq: assert property (txMoveSeq ##0 txIrqEn_q |=> txInt)
        else $error("Transfer to shifter raised no interrupt.");
    a_lin_idle: assert property (!sci_q |=> $stable(rxData_q) && $stable(txData_q)
        && !rxInt)
        else $error("Buffer changed outside SCI mode.");
    a_tx_mask: assert property (txMove |->
        8'(pushChar.data >> ({1'b0, pushChar.len} + 4'h1)) == 8'h00)
        else $error("Unused upper transmit bits reached the shifter.");
endmodule // sdb_data_buffers

`default_nettype wire

// *** rtl/sdb_pkg.sv ***
// Shared constants and carrier types for the serial data-buffer block.
package sdb_pkg;
    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int BUS_W = 32;
    // Character geometry.
    localparam int DATA_W = 8;
    localparam int LEN_W = 3;
    // Byte offsets of the registers.
    localparam logic [ADDR_W-1:0] OFS_EMUL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RXBUF = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TXBUF = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INTSET = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h14;
    // Field positions.
    localparam int INT_TX_BIT = 8;
    localparam int INT_RX_BIT = 9;
    localparam int FLAG_RX_READY_BIT = 9;
    localparam int FLAG_TX_READY_BIT = 23;
    localparam int CTRL_SCI_BIT = 0;
    localparam int CTRL_LEN_LSB = 4;
    // Reset values, length limit and data mask.
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [LEN_W-1:0] LEN_RESET = 3'h7;
    localparam logic [LEN_W-1:0] LEN_MAX = 3'h7;
    localparam logic [DATA_W-1:0] DATA_MASK = 8'hff;
    localparam logic [BUS_W-1:0] BUS_ZERO = 32'h0000_0000;
    // Depth of the transmit queue.
    localparam int FIFO_DEPTH = 32;

    // A character from the receive shift register, right-aligned.
    typedef struct packed {
        logic [LEN_W-1:0] len;
        logic [DATA_W-1:0] bits;
    } sdb_rxchar_t;

    // A character handed to the transmit shift register.
    typedef struct packed {
        logic [LEN_W-1:0] len;
        logic [DATA_W-1:0] data;
    } sdb_txchar_t;
endpackage

// *** testbench/sdb_data_buffers_test.sv ***
// Self-checking bench for the serial data-buffer block.
`timescale 1ns/1ps
`default_nettype none

module sdb_data_buffers_test;
    // Bench clock, reset and port nets.
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxDone = 1'b0;
    sdb_pkg::sdb_rxchar_t rxChar = '0;
    logic txValid;
    logic txReady = 1'b0;
    sdb_pkg::sdb_txchar_t txChar;
    logic sciMode;
    logic [2:0] charLen;
    logic rxInt;
    logic txInt;
    int err_total = 0; // Mismatches seen.
    int comparisons = 0; // Comparisons made.
    logic [31:0] rd; // Last read data.
    logic er; // Last error response.

    // Device under test.
    sdb_data_buffers uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxDone(rxDone), .rxChar(rxChar), .txValid(txValid),
        .txReady(txReady), .txChar(txChar), .sciMode(sciMode), .charLen(charLen),
        .rxInt(rxInt), .txInt(txInt));

    // The clock toggles every half period of 12.5 ns.
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // Prints the verdict and stops the run.
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compares a seen value against the expected one.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("MISMATCH at %0t: no bus answer", $time);
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sends one completed character and checks the interrupt pulse.
    task automatic rx_char(input logic [2:0] len, input logic [7:0] bits, input logic intExp);
        @(posedge mclk);
        rxDone <= 1'b1;
        rxChar <= '{len: len, bits: bits};
        @(posedge mclk);
        rxDone <= 1'b0;
        #1;
        check({31'h0, rxInt}, {31'h0, intExp}, "rx interrupt");
    endtask

    // Reset values and behaviour outside the compatible mode.
    task automatic test_reset_and_idle;
        apb(1'b0, 8'h00, 32'h0); check(rd, 32'h0, "emul reset");
        apb(1'b0, 8'h04, 32'h0); check(rd, 32'h0, "rx reset");
        apb(1'b0, 8'h08, 32'h0); check(rd, 32'h0, "tx reset");
        apb(1'b1, 8'h04, 32'h0000_00ff);
        apb(1'b0, 8'h04, 32'h0); check(rd, 32'h0, "rx write outside mode");
        rx_char(3'h7, 8'h5a, 1'b0);
        apb(1'b0, 8'h10, 32'h0); check(rd, 32'h0080_0000, "flags idle");
        apb(1'b0, 8'h40, 32'h0); check({rd[30:0], er}, 32'h1, "unmapped read");
        $display("Test reset and idle done");
    endtask

    // Receive path: alignment, flag, interrupt, emulation view, read clear.
    task automatic test_receive;
        apb(1'b1, 8'h14, 32'h0000_0041);
        #1;
        check({28'h0, sciMode, charLen}, 32'h0000_000c, "mode and length");
        rx_char(3'h4, 8'h15, 1'b0); // Interrupt disabled.
        apb(1'b1, 8'h0c, 32'h0000_0200);
        rx_char(3'h4, 8'h15, 1'b1);
        apb(1'b0, 8'h00, 32'h0); check(rd, 32'h0000_00a8, "emul aligned");
        apb(1'b0, 8'h10, 32'h0); check(rd, 32'h0080_0200, "flag kept");
        apb(1'b0, 8'h04, 32'h0); check(rd, 32'h0000_00a8, "rx aligned");
        check(rd >> (3'h7 - 3'h4), 32'h0000_0015, "rx right-aligned");
        apb(1'b0, 8'h10, 32'h0); check(rd, 32'h0080_0000, "flag cleared");
        apb(1'b1, 8'h04, 32'hffff_ff3c);
        apb(1'b0, 8'h00, 32'h0); check(rd, 32'h0000_003c, "rx write");
        apb(1'b1, 8'h00, 32'h0000_0011);
        apb(1'b0, 8'h04, 32'h0); check(rd, 32'h0000_003c, "emul read only");
        $display("Test receive done");
    endtask

    // Transmit path: masking, interrupt, full queue, drain.
    task automatic test_transmit;
        int seen;
        int pops;
        apb(1'b1, 8'h0c, 32'h0000_0100);
        apb(1'b1, 8'h08, 32'hffff_ffff);
        seen = 0;
        repeat (6) begin
            @(posedge mclk);
            #1;
            if (txInt === 1'b1) seen++;
        end
        check(seen, 32'h1, "tx interrupt");
        check({20'h0, txValid, txChar}, 32'h0000_0c1f, "tx head masked");
        apb(1'b0, 8'h08, 32'h0); check(rd, 32'h0000_00ff, "tx buffer readback");
        apb(1'b0, 8'h10, 32'h0); check(rd, 32'h0080_0000, "tx ready");
        for (int i = 1; i <= 32; i++) begin
            apb(1'b1, 8'h08, 32'h0000_00e0 + i);
        end
        repeat (3) @(posedge mclk);
        apb(1'b0, 8'h10, 32'h0); check(rd, 32'h0, "queue full");
        @(posedge mclk);
        txReady <= 1'b1;
        pops = 0;
        repeat (60) begin
            @(posedge mclk);
            if (txValid === 1'b1) begin
                check({21'h0, txChar}, {24'h4, 3'h0, (pops == 0) ? 5'h1f : pops[4:0]},
                    "tx order");
                pops++;
            end
        end
        check(pops, 32'd33, "pop count");
        apb(1'b0, 8'h10, 32'h0); check(rd, 32'h0080_0000, "tx ready after drain");
        $display("Test transmit done");
    endtask

    // Guard against a hang.
    initial begin
        #2000000;
        err_total++;
        $display("MISMATCH at %0t: run timed out", $time);
        end_sim();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        test_reset_and_idle();
        test_receive();
        test_transmit();
        end_sim();
    end
endmodule // sdb_data_buffers_test

`default_nettype wire
